// File: rtl/pwm_concat.sv
// Six-channel waveform generator with pair joining and a shutdown-pin interrupt flag; the flag does not force any waveform pin.
//
// What this block does
// - Alignment bit picks center or left mode.
// - Center mode counts up/down, up at zero.
// - Up-count duty match toggles output.
// - Period match reverses direction downward.
// - Down-count duty match toggles again.
// - Zero on down count: up, reload buffers.
// - Sweep zero to period and back.
// - Three join bits pair channels 45,23,01.
// - Even channel supplies the high bytes.
// - Joined clock from odd channel select.
// - Joined output, polarity on odd channel.
// - Odd enable only; even output held off.
// - Any counter byte write clears whole counter.
// - Joined alignment from odd channel bit.
// - Zero or oversized duty fixes output.
// - Zero period parks counter, output fixed.
// - Reset: count up, disabled, stopped.
// - One shutdown interrupt, gated by enable.
// - Shutdown flag on pin change or arming.
// - Polarity one starts high, drops at duty.
// - Writes buffered while enabled.
`timescale 1ns/1ps
module pwm_concat
  import pwm_pkg::*;
(
  // Clock and reset.
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Channel clock ticks: select bit zero takes tick_a, one takes tick_b.
  input  wire logic                  tick_a,
  input  wire logic                  tick_b,
  // Per-channel configuration.
  input  wire ch_cfg_t [NUM_CH-1:0]  cfg,
  // Pair join bits: bit 0 joins 0/1, bit 1 joins 2/3, bit 2 joins 4/5.
  input  wire logic [NUM_PAIRS-1:0]  concat_control_reg,
  // Period, duty and counter writes, one byte per channel.
  input  wire logic [NUM_CH-1:0]     per_we,
  input  wire logic [NUM_CH-1:0]     dty_we,
  input  wire logic [NUM_CH-1:0]     cnt_we,
  input  wire logic [NUM_CH*8-1:0]   wdata,
  // Counter readback, one byte per channel.
  output logic      [NUM_CH*8-1:0]   channel_counter,
  // Waveform pins.
  output logic      [NUM_CH-1:0]     waveform_output_pin,
  // Shutdown control, pin input and status.
  input  wire shdn_ctl_t             shutdown_control_reg,
  input  wire logic                  shdn_pin_in,
  input  wire logic                  shdn_flag_clear,
  output logic                       shutdown_irq_flag,
  output logic                       irq
);

  // Per-pair waveforms and counters from both widths.
  logic [NUM_CH-1:0]   wave8;
  logic [NUM_CH*8-1:0] cnt8;
  logic [NUM_PAIRS-1:0] wave16;
  logic [NUM_PAIRS*16-1:0] cnt16;

  // Each pair holds two 8-bit engines and one 16-bit engine.
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    localparam int HI = 2 * p;      // Even channel, high bytes.
    localparam int LO = 2 * p + 1;  // Odd channel, low bytes.
    logic joined;
    logic tick_hi;
    logic tick_lo;
    assign joined  = concat_control_reg[p];
    // Clock select picks between the two channel clock ticks.
    assign tick_hi = cfg[HI].channel_clock_select_bit ? tick_b : tick_a;
    assign tick_lo = cfg[LO].channel_clock_select_bit ? tick_b : tick_a;

    // The high 8-bit engine is idle whenever the pair is joined.
    pwm_lane #(.W(8)) u_hi (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .tick      (tick_hi),
      .enable    (cfg[HI].channel_enable_bit && !joined),
      .center    (cfg[HI].center_align_select_bit),
      .polarity  (cfg[HI].channel_polarity_bit),
      .per_we    (per_we[HI] && !joined),
      .per_wdata (wdata[HI*8 +: 8]),
      .dty_we    (dty_we[HI] && !joined),
      .dty_wdata (wdata[HI*8 +: 8]),
      .cnt_we    (cnt_we[HI] && !joined),
      .count     (cnt8[HI*8 +: 8]),
      .wave      (wave8[HI])
    );
    pwm_lane #(.W(8)) u_lo (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .tick      (tick_lo),
      .enable    (cfg[LO].channel_enable_bit && !joined),
      .center    (cfg[LO].center_align_select_bit),
      .polarity  (cfg[LO].channel_polarity_bit),
      .per_we    (per_we[LO] && !joined),
      .per_wdata (wdata[LO*8 +: 8]),
      .dty_we    (dty_we[LO] && !joined),
      .dty_wdata (wdata[LO*8 +: 8]),
      .cnt_we    (cnt_we[LO] && !joined),
      .count     (cnt8[LO*8 +: 8]),
      .wave      (wave8[LO])
    );

    // Byte writes into the joined engine keep the other byte's buffer.
    logic [15:0] per16_reg;
    logic [15:0] dty16_reg;
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        per16_reg <= 16'h0000;
        dty16_reg <= 16'h0000;
      end else begin
        if (per_we[HI]) begin
          per16_reg[15:8] <= wdata[HI*8 +: 8];
        end
        if (per_we[LO]) begin
          per16_reg[7:0] <= wdata[LO*8 +: 8];
        end
        if (dty_we[HI]) begin
          dty16_reg[15:8] <= wdata[HI*8 +: 8];
        end
        if (dty_we[LO]) begin
          dty16_reg[7:0] <= wdata[LO*8 +: 8];
        end
      end
    end

    // Joined engine takes clock, mode, polarity and enable from the odd channel.
    pwm_lane #(.W(16)) u_wide (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .tick      (tick_lo),
      .enable    (cfg[LO].channel_enable_bit && joined),
      .center    (cfg[LO].center_align_select_bit),
      .polarity  (cfg[LO].channel_polarity_bit),
      .per_we    (joined && (per_we[HI] || per_we[LO])),
      .per_wdata ({per_we[HI] ? wdata[HI*8 +: 8] : per16_reg[15:8],
                   per_we[LO] ? wdata[LO*8 +: 8] : per16_reg[7:0]}),
      .dty_we    (joined && (dty_we[HI] || dty_we[LO])),
      .dty_wdata ({dty_we[HI] ? wdata[HI*8 +: 8] : dty16_reg[15:8],
                   dty_we[LO] ? wdata[LO*8 +: 8] : dty16_reg[7:0]}),
      .cnt_we    (joined && (cnt_we[HI] || cnt_we[LO])),
      .count     (cnt16[p*16 +: 16]),
      .wave      (wave16[p])
    );

    // Output steering and counter readback per pair.
    always_comb begin
      if (joined) begin
        waveform_output_pin[LO]     = cfg[LO].channel_enable_bit ? wave16[p] : 1'b0;
        waveform_output_pin[HI]     = 1'b0;
        channel_counter[HI*8 +: 8]  = cnt16[p*16 + 8 +: 8];
        channel_counter[LO*8 +: 8]  = cnt16[p*16 +: 8];
      end else begin
        waveform_output_pin[LO]     = cfg[LO].channel_enable_bit ? wave8[LO] : 1'b0;
        waveform_output_pin[HI]     = cfg[HI].channel_enable_bit ? wave8[HI] : 1'b0;
        channel_counter[HI*8 +: 8]  = cnt8[HI*8 +: 8];
        channel_counter[LO*8 +: 8]  = cnt8[LO*8 +: 8];
      end
    end
  end

  // Shutdown pin synchroniser; the first stage feeds only the second.
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic level_reg;     // Settled pin level, changes once stages two and three agree.
  logic fn_d_reg;      // Delayed function-active bit for edge detection.

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= shdn_pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Settled level follows the pin when the last two stages agree.
  logic level_next;
  assign level_next = (sync2_reg == sync3_reg) ? sync3_reg : level_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      level_reg <= 1'b0;
      fn_d_reg  <= 1'b0;
    end else begin
      level_reg <= level_next;
      fn_d_reg  <= shutdown_control_reg.shutdown_function_active;
    end
  end

  // Flag set on a pin change or on arming at the active level; set beats clear.
  logic shdn_event;
  assign shdn_event =
    (shutdown_control_reg.shutdown_input_enable && level_next != level_reg) ||
    (shutdown_control_reg.shutdown_function_active && !fn_d_reg &&
     level_reg == shutdown_control_reg.shutdown_active_level);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shutdown_irq_flag <= 1'b0;
    end else if (shdn_event) begin
      shutdown_irq_flag <= 1'b1;
    end else if (shdn_flag_clear) begin
      shutdown_irq_flag <= 1'b0;
    end
  end

  // The single interrupt line, gated by its enable.
  assign irq = shutdown_irq_flag && shutdown_control_reg.shutdown_irq_enable;

endmodule

// File: rtl/pwm_pkg.sv
// Package with shared constants and carrier types for the six-channel waveform generator.
package pwm_pkg;

  // Number of 8-bit channels and of joinable pairs.
  localparam int NUM_CH    = 6;
  localparam int NUM_PAIRS = 3;

  // Value of the counter and direction after reset.
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic       DIR_UP    = 1'b0;
  localparam logic       DIR_DOWN  = 1'b1;

  // Index of the channel whose pin doubles as the shutdown input.
  localparam int SHDN_CH = 5;

  // Per-channel configuration bits that travel together.
  typedef struct packed {
    logic channel_enable_bit;
    logic center_align_select_bit;
    logic channel_polarity_bit;
    logic channel_clock_select_bit;
  } ch_cfg_t;

  // Shutdown control group.
  typedef struct packed {
    logic shutdown_irq_enable;
    logic shutdown_input_enable;
    logic shutdown_function_active;
    logic shutdown_active_level;
  } shdn_ctl_t;

endpackage

// File: rtl/pwm_lane.sv
// One waveform engine of configurable width: counter, compare, buffers and output.
`timescale 1ns/1ps
module pwm_lane
  import pwm_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset.
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Control.
  input  wire logic         tick,
  input  wire logic         enable,
  input  wire logic         center,
  input  wire logic         polarity,
  // Software writes.
  input  wire logic         per_we,
  input  wire logic [W-1:0] per_wdata,
  input  wire logic         dty_we,
  input  wire logic [W-1:0] dty_wdata,
  input  wire logic         cnt_we,
  // Observation.
  output logic      [W-1:0] count,
  output logic              wave
);

  // Width check at elaboration: the engine serves 8-bit or 16-bit channels only.
  if (W != 8 && W != 16) begin : g_bad_width
    $error("pwm_lane supports only widths 8 and 16");
  end

  logic [W-1:0] per_buf_reg;  // Buffered period written by software.
  logic [W-1:0] dty_buf_reg;  // Buffered duty written by software.
  logic [W-1:0] per_act_reg;  // Active period used by the compare.
  logic [W-1:0] dty_act_reg;  // Active duty used by the compare.
  logic [W-1:0] cnt_reg;      // Channel counter.
  logic         dir_reg;      // Count direction, up after reset.
  logic         ff_reg;       // Output flip-flop, low at start of cycle.
  logic         en_d_reg;     // Enable delayed, to spot a disable.

  logic         per_match;
  logic         dty_match;
  logic         end_left;
  logic         end_center;
  logic         reload;
  logic         step;

  assign per_match  = (cnt_reg == per_act_reg);
  assign dty_match  = (cnt_reg == dty_act_reg);
  // The counter only moves on a channel clock tick while enabled.
  assign step       = tick && enable && (per_act_reg != '0);
  // Left mode ends its period when the count reaches period less one.
  assign end_left   = step && !center && (cnt_reg == per_act_reg - W'(1));
  // Center mode ends when the down count reaches zero.
  // A period of one turns at the top and reaches zero in the same step.
  assign end_center = step && center && cnt_reg == W'(1) && (dir_reg == DIR_DOWN || per_match);
  // Buffers load at period end, on a counter write or on disable.
  assign reload     = end_left || end_center || cnt_we || (en_d_reg && !enable);

  // Buffer registers always capture writes.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      per_buf_reg <= '0;
      dty_buf_reg <= '0;
    end else begin
      if (per_we) begin
        per_buf_reg <= per_wdata;
      end
      if (dty_we) begin
        dty_buf_reg <= dty_wdata;
      end
    end
  end

  // Active compare registers: direct when disabled, else at reload.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      per_act_reg <= '0;
      dty_act_reg <= '0;
    end else begin
      if (!enable && per_we) begin
        per_act_reg <= per_wdata;
      end else if (reload) begin
        per_act_reg <= per_we ? per_wdata : per_buf_reg;
      end
      if (!enable && dty_we) begin
        dty_act_reg <= dty_wdata;
      end else if (reload) begin
        dty_act_reg <= dty_we ? dty_wdata : dty_buf_reg;
      end
    end
  end

  // Counter, direction and output flip-flop.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      dir_reg <= DIR_UP;
      ff_reg  <= 1'b0;
    end else if (cnt_we) begin
      // A counter write restarts the whole period from zero.
      cnt_reg <= '0;
      dir_reg <= DIR_UP;
      ff_reg  <= 1'b0;
    end else if (per_act_reg == '0) begin
      // Zero period parks the counter on the next tick.
      if (tick) begin
        cnt_reg <= '0;
        dir_reg <= DIR_UP;
        ff_reg  <= 1'b0;
      end
    end else if (step) begin
      if (!center) begin
        // Left aligned: count up, clear at period end.
        if (end_left) begin
          cnt_reg <= '0;
          ff_reg  <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg + W'(1);
          if (cnt_reg + W'(1) == dty_act_reg) begin
            ff_reg <= ~ff_reg;
          end
        end
        dir_reg <= DIR_UP;
      end else if (dir_reg == DIR_UP) begin
        // Up count; period match turns direction down.
        if (per_match && cnt_reg == W'(1)) begin
          // The next count is zero, so the direction must stay up.
          cnt_reg <= '0;
          ff_reg  <= 1'b0;
        end else if (per_match) begin
          dir_reg <= DIR_DOWN;
          cnt_reg <= cnt_reg - W'(1);
          if (cnt_reg - W'(1) == dty_act_reg) begin
            ff_reg <= ~ff_reg;
          end
        end else begin
          cnt_reg <= cnt_reg + W'(1);
          if (cnt_reg + W'(1) == dty_act_reg) begin
            ff_reg <= ~ff_reg;
          end
        end
      end else begin
        // Down count; reaching zero turns direction up.
        cnt_reg <= cnt_reg - W'(1);
        if (cnt_reg == W'(1)) begin
          dir_reg <= DIR_UP;
          ff_reg  <= 1'b0;
        end else if (cnt_reg - W'(1) == dty_act_reg) begin
          ff_reg <= ~ff_reg;
        end
      end
    end
  end

  // Delayed enable for disable detection.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= enable;
    end
  end

  // Output with boundary cases; flip-flop high means past duty point.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wave <= 1'b0;
    end else if (per_act_reg == '0) begin
      wave <= polarity;
    end else if (dty_act_reg == '0) begin
      wave <= ~polarity;
    end else if (dty_act_reg >= per_act_reg) begin
      wave <= polarity;
    end else begin
      // Polarity one starts high and drops at the duty match.
      wave <= polarity ^ ff_reg;
    end
  end

  assign count = cnt_reg;

endmodule

// File: sim/pwm_concat_sva.sv
// Checker with the timing relations of the six-channel waveform generator.
`timescale 1ns/1ps
module pwm_concat_chk
  import pwm_pkg::*;
(
  // Clock and reset.
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  // Ticks, configuration and counter writes.
  input wire logic                 tick_a,
  input wire logic                 tick_b,
  input wire ch_cfg_t [NUM_CH-1:0] cfg,
  input wire logic [NUM_PAIRS-1:0] concat_control_reg,
  input wire logic [NUM_CH-1:0]    cnt_we,
  // Observed outputs.
  input wire logic [NUM_CH*8-1:0]  channel_counter,
  input wire logic [NUM_CH-1:0]    waveform_output_pin,
  input wire shdn_ctl_t            shutdown_control_reg,
  input wire logic                 shutdown_irq_flag,
  input wire logic                 irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Selected channel clocks for channel 0 alone and for the joined pair 0/1.
  logic        tk0;
  logic        tk1;
  logic        j0;
  logic [7:0]  c8;
  logic [15:0] c16;
  assign tk0 = cfg[0].channel_clock_select_bit ? tick_b : tick_a;
  assign tk1 = cfg[1].channel_clock_select_bit ? tick_b : tick_a;
  assign j0  = concat_control_reg[0];
  assign c8  = channel_counter[7:0];
  assign c16 = {channel_counter[7:0], channel_counter[15:8]};

  // The join bit held over two edges, so the readback source is settled.
  sequence s_joined;
    j0 ##1 j0;
  endsequence
  sequence s_single;
    !j0 ##1 !j0;
  endsequence

  property p_reset;
    disable iff (1'b0) !rst_n |=> (channel_counter == '0) && (waveform_output_pin == '0)
      && !shutdown_irq_flag;
  endproperty
  a_reset: assert property (p_reset) else $error("State not cleared by reset.");
  property p_irq;
    irq == (shutdown_irq_flag && shutdown_control_reg.shutdown_irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt not flag and enable.");
  property p_hold8;
    s_single ##0 (!cnt_we[0] && !tk0) ##1 !j0 |-> $stable(c8);
  endproperty
  a_hold8: assert property (p_hold8) else $error("Counter moved without tick.");
  property p_step8;
    s_single ##0 $changed(c8) |-> (c8 == $past(c8) + 8'h01) || (c8 == $past(c8) - 8'h01)
      || (c8 == 8'h00);
  endproperty
  a_step8: assert property (p_step8) else $error("Counter jumped.");
  property p_even_off;
    s_joined |-> !waveform_output_pin[0];
  endproperty
  a_even_off: assert property (p_even_off) else $error("High pin of pair active.");
  property p_clr8;
    s_single ##0 cnt_we[0] |=> c8 == 8'h00;
  endproperty
  a_clr8: assert property (p_clr8) else $error("Counter write did not clear.");
  property p_clr16;
    j0 && (cnt_we[0] || cnt_we[1]) |=> c16 == 16'h0000;
  endproperty
  a_clr16: assert property (p_clr16) else $error("Byte write left 16-bit count.");
  property p_hold16;
    s_joined ##0 (cnt_we[1:0] == 2'b00 && !tk1) ##1 j0 |-> $stable(c16);
  endproperty
  a_hold16: assert property (p_hold16) else $error("Pair moved on wrong clock.");
  property p_en16;
    s_joined ##0 (cnt_we[1:0] == 2'b00 && !cfg[1].channel_enable_bit)
      |=> $stable(c16) || (c16 == 16'h0000);
  endproperty
  a_en16: assert property (p_en16) else $error("Pair ran while disabled.");
  property p_flag;
    $rose(shutdown_irq_flag) |-> $past(shutdown_control_reg.shutdown_input_enable)
      || $past(shutdown_control_reg.shutdown_function_active);
  endproperty
  a_flag: assert property (p_flag) else $error("Flag set while unarmed.");
endmodule

bind pwm_concat pwm_concat_chk u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .tick_a(tick_a), .tick_b(tick_b), .cfg(cfg),
  .concat_control_reg(concat_control_reg), .cnt_we(cnt_we),
  .channel_counter(channel_counter), .waveform_output_pin(waveform_output_pin),
  .shutdown_control_reg(shutdown_control_reg), .shutdown_irq_flag(shutdown_irq_flag),
  .irq(irq)
);

// File: sim/pwm_load.sv
// Load model that counts high cycles on each waveform pin inside a window.
`timescale 1ns/1ps
module pwm_load
  import pwm_pkg::*;
(
  // Clock.
  input  wire logic                   ref_clk,
  // Observed pins and measurement window.
  input  wire logic [NUM_CH-1:0]      pins,
  input  wire logic                   win,
  // High-cycle counts per pin.
  output logic      [NUM_CH-1:0][7:0] high_cnt
);
  // A closed window clears the counts, so each measurement starts at zero.
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      high_cnt[i] <= win ? high_cnt[i] + 8'(pins[i]) : 8'h00;
    end
  end
endmodule

// File: sim/pwm_concat_test.sv
// Self-checking testbench for the six-channel waveform generator.
`timescale 1ns/1ps
module pwm_concat_test
  import pwm_pkg::*;
;
  logic                   ref_clk         = 1'b0;
  logic                   rst_n           = 1'b0;
  logic                   tick_a          = 1'b0;
  logic                   tick_b          = 1'b0;
  ch_cfg_t [NUM_CH-1:0]   cfg             = '0;
  logic [NUM_PAIRS-1:0]   join_bits       = '0;
  logic [NUM_CH-1:0]      per_we          = '0;
  logic [NUM_CH-1:0]      dty_we          = '0;
  logic [NUM_CH-1:0]      cnt_we          = '0;
  logic [NUM_CH*8-1:0]    wdata           = '0;
  shdn_ctl_t              sc              = '0;
  logic                   shdn_pin_in     = 1'b0;
  logic                   shdn_flag_clear = 1'b0;
  logic                   win             = 1'b0;
  logic [NUM_CH*8-1:0]    cnt;
  logic [NUM_CH-1:0]      pins;
  logic                   flag;
  logic                   irq;
  logic [NUM_CH-1:0][7:0] high_cnt;
  int                     num_errors      = 0;
  int                     samples_checked = 0;
  int                     cycles          = 0;
  // Expected center-mode sweep for a period of four.
  logic [7:0]             seq [8]         = '{8'h01, 8'h02, 8'h03, 8'h04,
                                              8'h03, 8'h02, 8'h01, 8'h00};

  pwm_concat DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .tick_a(tick_a), .tick_b(tick_b), .cfg(cfg),
    .concat_control_reg(join_bits), .per_we(per_we), .dty_we(dty_we), .cnt_we(cnt_we),
    .wdata(wdata), .channel_counter(cnt), .waveform_output_pin(pins),
    .shutdown_control_reg(sc), .shdn_pin_in(shdn_pin_in),
    .shdn_flag_clear(shdn_flag_clear), .shutdown_irq_flag(flag), .irq(irq)
  );
  pwm_load load (.ref_clk(ref_clk), .pins(pins), .win(win), .high_cnt(high_cnt));

  // Clock at 125 MHz.
  always #4 ref_clk = ~ref_clk;

  // The run takes about 600 cycles, so this ceiling only trips on a hang.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Inputs always change 1 ns after the rising edge.
  task automatic step(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One byte write; the idle cycle after it keeps strobes from being reassigned at once.
  task automatic wr(int kind, int ch, logic [7:0] val);
    wdata[ch*8 +: 8] = val;
    per_we[ch] = (kind == 0);
    dty_we[ch] = (kind == 1);
    cnt_we[ch] = (kind == 2);
    step();
    per_we[ch] = 1'b0;
    dty_we[ch] = 1'b0;
    cnt_we[ch] = 1'b0;
    step();
  endtask

  // Disabled writes land in the active values directly, then the counter starts clean.
  task automatic setup(int ch, logic [7:0] per, logic [7:0] dty);
    cfg[ch].channel_enable_bit = 1'b0;
    step();
    wr(0, ch, per);
    wr(1, ch, dty);
    wr(2, ch, 8'h00);
  endtask

  task automatic t_reset();
    tick_a = 1'b1;
    tick_b = 1'b1;
    step(4);
    for (int i = 0; i < 3; i++) begin
      check(cnt[i*16 +: 16], 16'h0000);
    end
    check(16'(pins), 16'h0000);
    check(16'(flag), 16'h0000);
    tick_a = 1'b0;
    tick_b = 1'b0;
    $display("reset test done");
  endtask

  // Left mode counts 0 to period less one; center mode sweeps up and down.
  task automatic t_center(logic ctr, logic pol, int highs);
    logic [15:0] exp_cnt;
    setup(0, 8'h04, 8'h01);
    cfg[0] = {1'b0, ctr, pol, 1'b0};
    step();
    cfg[0].channel_enable_bit = 1'b1;
    tick_a = 1'b1;
    for (int r = 0; r < 2; r++) begin
      win = (r == 1);
      for (int k = 0; k < 8; k++) begin
        step();
        exp_cnt = ctr ? 16'(seq[k]) : 16'((k + 1) % 4);
        check(16'(cnt[7:0]), exp_cnt);
      end
    end
    check(16'(high_cnt[0]), 16'(highs));
    win = 1'b0;
    $display("center test done");
  endtask

  // Channel 0 is running; a zero period waits for the period end or a counter write to take effect.
  task automatic t_buffer();
    wr(0, 0, 8'h00);
    check(16'(cnt[7:0]), 16'h0002);
    step();
    check(16'(cnt[7:0]), 16'h0003);
    wr(2, 0, 8'h00);
    step();
    check(16'(cnt[7:0]), 16'h0000);
    tick_a = 1'b0;
    cfg[0] = '0;
    $display("buffer test done");
  endtask

  task automatic t_bound();
    int         pt [6] = '{4, 4, 0, 0, 4, 4};
    int         dt [6] = '{0, 0, 3, 3, 4, 9};
    logic [5:0] lv     = 6'b010110;
    tick_b = 1'b1;
    for (int i = 0; i < 6; i++) begin
      setup(2, 8'(pt[i]), 8'(dt[i]));
      cfg[2] = {1'b1, i[1], ~i[0], 1'b1};
      step(3);
      win = 1'b1;
      step(8);
      check(16'(high_cnt[2]), lv[i] ? 16'h0008 : 16'h0000);
      if (pt[i] == 0) begin
        check(16'(cnt[23:16]), 16'h0000);
      end
      win = 1'b0;
    end
    tick_b = 1'b0;
    cfg[2] = '0;
    $display("boundary test done");
  endtask

  task automatic t_join();
    join_bits[0] = 1'b1;
    wr(0, 0, 8'h00);
    wr(0, 1, 8'h04);
    wr(1, 0, 8'h00);
    wr(1, 1, 8'h01);
    wr(2, 1, 8'h00);
    // High channel set to left mode, polarity zero and clock A, all to be ignored.
    cfg[0] = {1'b1, 1'b0, 1'b0, 1'b0};
    cfg[1] = {1'b1, 1'b1, 1'b1, 1'b1};
    tick_b = 1'b1;
    step(8);
    win = 1'b1;
    step(8);
    check(16'(high_cnt[1]), 16'h0002);
    check(16'(high_cnt[0]), 16'h0000);
    win = 1'b0;
    step(5);
    check({cnt[7:0], cnt[15:8]}, 16'h0003);
    tick_b = 1'b0;
    tick_a = 1'b1;
    step(3);
    check({cnt[7:0], cnt[15:8]}, 16'h0003);
    tick_a = 1'b0;
    cfg[1].channel_enable_bit = 1'b0;
    tick_b = 1'b1;
    step(3);
    check({cnt[7:0], cnt[15:8]}, 16'h0003);
    tick_b = 1'b0;
    wr(2, 0, 8'h00);
    check({cnt[7:0], cnt[15:8]}, 16'h0000);
    wr(0, 0, 8'h01);
    wr(0, 1, 8'h00);
    cfg[1].channel_enable_bit = 1'b1;
    tick_b = 1'b1;
    // The count passes 255, so the even channel's byte must read back one.
    step(256);
    check({cnt[7:0], cnt[15:8]}, 16'h0100);
    tick_b = 1'b0;
    cfg = '0;
    step();
    join_bits[0] = 1'b0;
    $display("join test done");
  endtask

  task automatic t_shdn();
    sc = {1'b0, 1'b1, 1'b1, 1'b1};
    step(6);
    check(16'(flag), 16'h0000);
    shdn_pin_in = 1'b1;
    step(6);
    check(16'(flag), 16'h0001);
    check(16'(irq), 16'h0000);
    sc.shutdown_irq_enable = 1'b1;
    step();
    check(16'(irq), 16'h0001);
    sc.shutdown_function_active = 1'b0;
    sc.shutdown_input_enable = 1'b0;
    shdn_flag_clear = 1'b1;
    step();
    shdn_flag_clear = 1'b0;
    // With the input disabled, pin changes leave the flag clear.
    shdn_pin_in = 1'b0;
    step(6);
    check(16'(flag), 16'h0000);
    shdn_pin_in = 1'b1;
    step(6);
    check(16'(flag), 16'h0000);
    check(16'(irq), 16'h0000);
    // Arming at the active level meets a clear in the same cycle; the set wins.
    sc.shutdown_function_active = 1'b1;
    shdn_flag_clear = 1'b1;
    step();
    shdn_flag_clear = 1'b0;
    step(6);
    check(16'(flag), 16'h0001);
    check(16'(irq), 16'h0001);
    $display("shutdown test done");
  endtask

  // Reset is held for 16 cycles, then the scenarios run in turn.
  initial begin
    step(16);
    rst_n = 1'b1;
    step();
    t_reset();
    t_center(1'b1, 1'b0, 6);
    t_center(1'b1, 1'b1, 2);
    t_center(1'b0, 1'b0, 6);
    t_buffer();
    t_bound();
    t_join();
    t_shdn();
    report_and_stop();
  end
endmodule
